// [include/udi_pkg.sv]
package udi_pkg;
  localparam logic [31:0] ADDR_SHARED_DATA  = 32'h5000_1100;
  localparam logic [31:0] ADDR_IRQ_EN_DIVHI = 32'h5000_1104;
  localparam logic [31:0] ADDR_LINE_CONTROL = 32'h5000_1110;
  localparam logic [31:0] ADDR_LINE_STATUS  = 32'h5000_1114;
  localparam logic [31:0] ADDR_IRQ_STATUS   = 32'h5000_1118;
  localparam logic [31:0] ADDR_IRQ_MASK     = 32'h5000_111C;

  localparam int BIT_DIVISOR_ACCESS = 7;
  localparam int BIT_FIFO_ENABLE    = 0;
  localparam int BIT_IR_MODE        = 1;

  localparam int BIT_RX_READY       = 0;
  localparam int BIT_OVERRUN        = 1;
  localparam int BIT_TX_EMPTY       = 5;

  localparam int BIT_RX_AVAIL_EN    = 0;
  localparam int BIT_TX_EMPTY_EN    = 1;
  localparam int BIT_LINE_STATUS_EN = 2;
  localparam int BIT_MODEM_EN       = 3;
  localparam int BIT_PROG_TX_EMPTY  = 7;
  localparam logic [7:0] IRQ_EN_USED = 8'h8F;

  localparam int IRQ_RX   = 0;
  localparam int IRQ_OVR  = 1;
  localparam int IRQ_TX   = 2;

  localparam int         FIFO_DEPTH   = 16;
  localparam logic [4:0] FIFO_CAP     = 5'h10;
  localparam logic [3:0] OVERSAMPLE_L = 4'hF;
  localparam logic [3:0] MID_SAMPLE   = 4'h7;
  localparam logic [2:0] LAST_BIT     = 3'h7;

  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [2:0]  RESET_IRQ   = 3'h0;
  localparam logic [15:0] RESET_COUNT = 16'h0000;

  typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} udi_state_type;
endpackage

// [hw/udi_uart.sv]
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module udi_uart (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sin,
  input  wire logic        sir_in,
  output logic             sout,
  output logic             sir_out_n,
  output logic             irq
);
  typedef struct packed {
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
    logic [7:0]             line_control;
    logic [7:0]             divisor_low_byte;
    logic [7:0]             divisor_high_byte;
    logic [7:0]             irq_enable;
    logic [2:0]             irq_status;
    logic [2:0]             irq_mask;
    logic                   irq;
    logic                   overrun;
    logic [15:0]            baud_cnt;
    logic                   tick;
    udi_pkg::udi_state_type rx_state;
    logic [3:0]             rx_sub;
    logic [2:0]             rx_bit;
    logic [7:0]             rx_shift;
    logic [15:0][7:0]       rx_mem;
    logic [3:0]             rx_wp;
    logic [3:0]             rx_rp;
    logic [4:0]             rx_cnt;
    udi_pkg::udi_state_type tx_state;
    logic [3:0]             tx_sub;
    logic [2:0]             tx_bit;
    logic [7:0]             tx_shift;
    logic [15:0][7:0]       tx_mem;
    logic [3:0]             tx_wp;
    logic [3:0]             tx_rp;
    logic [4:0]             tx_cnt;
    logic                   tx_line;
    logic                   sout;
    logic                   sir_out_n;
  } udi_st_type;

  udi_st_type st_reg;
  udi_st_type st_next;
  logic        access;
  logic        wr;
  logic        rd;
  logic        div_access;
  logic        fifo_en;
  logic        ir_mode;
  logic [15:0] divisor;
  logic        rx_line;
  logic        tx_empty_flag;
  logic        rx_push;
  logic        tx_write;
  logic [2:0]  irq_set;
  logic [2:0]  irq_clr;

  // Without FIFOs both paths behave as a one-entry holding stage.
  function automatic logic [4:0] cap(input logic en);
    cap = en ? udi_pkg::FIFO_CAP : 5'h01;
  endfunction
  assign access     = psel && penable && !st_reg.pready;
  assign wr         = access && pwrite;
  assign rd         = access && !pwrite;
  assign div_access = st_reg.line_control[udi_pkg::BIT_DIVISOR_ACCESS];
  assign fifo_en    = st_reg.line_control[udi_pkg::BIT_FIFO_ENABLE];
  assign ir_mode    = st_reg.line_control[udi_pkg::BIT_IR_MODE];
  assign divisor    = {st_reg.divisor_high_byte, st_reg.divisor_low_byte};
  assign rx_line    = ir_mode ? sir_in : sin;
  // With FIFOs on, programmable mode turns the flag into a FIFO-not-full indication.
  assign tx_empty_flag = (fifo_en &&
                          st_reg.irq_enable[udi_pkg::BIT_PROG_TX_EMPTY]) ?
                         (st_reg.tx_cnt != udi_pkg::FIFO_CAP) :
                         (st_reg.tx_cnt == 5'h00);
  always_comb begin
    st_next          = st_reg;
    st_next.pready   = access;
    st_next.pslverr  = 1'b0;
    rx_push          = 1'b0;
    tx_write         = 1'b0;
    irq_set          = 3'h0;
    irq_clr          = 3'h0;
    // The divider runs on clk; a zero divisor parks both shifters.
    st_next.tick = 1'b0;
    if (divisor == 16'h0000) begin
      st_next.baud_cnt = udi_pkg::RESET_COUNT;
    end else if (st_reg.baud_cnt >= divisor - 16'h0001) begin
      st_next.baud_cnt = udi_pkg::RESET_COUNT;
      st_next.tick     = 1'b1;
    end else begin
      st_next.baud_cnt = st_reg.baud_cnt + 16'h0001;
    end

    // Receiver, sampled at mid-bit of sixteen ticks per bit.
    if (st_reg.tick) begin
      unique case (st_reg.rx_state)
        udi_pkg::S_IDLE: begin
          st_next.rx_sub = 4'h0;
          if (!rx_line) begin
            st_next.rx_state = udi_pkg::S_START;
          end
        end
        udi_pkg::S_START: begin
          st_next.rx_sub = st_reg.rx_sub + 4'h1;
          if (st_reg.rx_sub == udi_pkg::MID_SAMPLE) begin
            st_next.rx_sub   = 4'h0;
            st_next.rx_bit   = 3'h0;
            st_next.rx_state = rx_line ? udi_pkg::S_IDLE : udi_pkg::S_DATA;
          end
        end
        udi_pkg::S_DATA: begin
          st_next.rx_sub = st_reg.rx_sub + 4'h1;
          if (st_reg.rx_sub == udi_pkg::OVERSAMPLE_L) begin
            st_next.rx_shift = {rx_line, st_reg.rx_shift[7:1]};
            st_next.rx_bit   = st_reg.rx_bit + 3'h1;
            if (st_reg.rx_bit == udi_pkg::LAST_BIT) begin
              st_next.rx_state = udi_pkg::S_STOP;
            end
          end
        end
        udi_pkg::S_STOP: begin
          st_next.rx_sub = st_reg.rx_sub + 4'h1;
          if (st_reg.rx_sub == udi_pkg::OVERSAMPLE_L) begin
            // A character with a bad stop bit is dropped silently.
            rx_push          = rx_line;
            st_next.rx_state = udi_pkg::S_IDLE;
          end
        end
      endcase
    end
    if (st_reg.tick) begin
      unique case (st_reg.tx_state)
        udi_pkg::S_IDLE: begin
          st_next.tx_line = 1'b1;
          if (st_reg.tx_cnt != 5'h00) begin
            st_next.tx_shift = st_reg.tx_mem[st_reg.tx_rp];
            st_next.tx_rp    = st_reg.tx_rp + (fifo_en ? 4'h1 : 4'h0);
            st_next.tx_cnt   = st_reg.tx_cnt - 5'h01;
            st_next.tx_line  = 1'b0;
            st_next.tx_sub   = 4'h0;
            st_next.tx_state = udi_pkg::S_START;
            if (st_reg.tx_cnt == 5'h01) begin
              irq_set[udi_pkg::IRQ_TX] =
                st_reg.irq_enable[udi_pkg::BIT_TX_EMPTY_EN];
            end
          end
        end
        udi_pkg::S_START: begin
          st_next.tx_sub = st_reg.tx_sub + 4'h1;
          if (st_reg.tx_sub == udi_pkg::OVERSAMPLE_L) begin
            st_next.tx_line  = st_reg.tx_shift[0];
            st_next.tx_bit   = 3'h0;
            st_next.tx_state = udi_pkg::S_DATA;
          end
        end
        udi_pkg::S_DATA: begin
          st_next.tx_sub = st_reg.tx_sub + 4'h1;
          if (st_reg.tx_sub == udi_pkg::OVERSAMPLE_L) begin
            st_next.tx_shift = {1'b1, st_reg.tx_shift[7:1]};
            st_next.tx_line  = st_reg.tx_shift[1];
            st_next.tx_bit   = st_reg.tx_bit + 3'h1;
            if (st_reg.tx_bit == udi_pkg::LAST_BIT) begin
              st_next.tx_line  = 1'b1;
              st_next.tx_state = udi_pkg::S_STOP;
            end
          end
        end
        udi_pkg::S_STOP: begin
          st_next.tx_sub = st_reg.tx_sub + 4'h1;
          if (st_reg.tx_sub == udi_pkg::OVERSAMPLE_L) begin
            st_next.tx_state = udi_pkg::S_IDLE;
          end
        end
      endcase
    end
    st_next.sout      = ir_mode ? 1'b1 : st_next.tx_line;
    st_next.sir_out_n = ir_mode ? st_next.tx_line : 1'b1;

    // Register reads; a shared data read outside divisor access pops the receive head.
    st_next.prdata = 32'h0000_0000;
    if (rd) begin
      unique case (paddr)
        udi_pkg::ADDR_SHARED_DATA: begin
          if (div_access) begin
            st_next.prdata[7:0] = st_reg.divisor_low_byte;
          end else if (st_reg.rx_cnt != 5'h00) begin
            st_next.prdata[7:0] = st_reg.rx_mem[st_reg.rx_rp];
            st_next.rx_rp  = st_reg.rx_rp + (fifo_en ? 4'h1 : 4'h0);
            st_next.rx_cnt = st_reg.rx_cnt - 5'h01;
          end
        end
        udi_pkg::ADDR_IRQ_EN_DIVHI: begin
          st_next.prdata[7:0] = div_access ? st_reg.divisor_high_byte :
                                st_reg.irq_enable;
        end
        udi_pkg::ADDR_LINE_CONTROL: st_next.prdata[7:0] = st_reg.line_control;
        udi_pkg::ADDR_LINE_STATUS: begin
          st_next.prdata[udi_pkg::BIT_RX_READY] =
            (st_reg.rx_cnt != 5'h00);
          st_next.prdata[udi_pkg::BIT_OVERRUN]  = st_reg.overrun;
          st_next.prdata[udi_pkg::BIT_TX_EMPTY] = tx_empty_flag;
          st_next.overrun = 1'b0;
        end
        udi_pkg::ADDR_IRQ_STATUS: st_next.prdata[2:0] = st_reg.irq_status;
        udi_pkg::ADDR_IRQ_MASK:   st_next.prdata[2:0] = st_reg.irq_mask;
        default:                  st_next.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        udi_pkg::ADDR_SHARED_DATA: begin
          if (div_access) begin
            st_next.divisor_low_byte = pwdata[7:0];
          end else begin
            tx_write = 1'b1;
          end
        end
        udi_pkg::ADDR_IRQ_EN_DIVHI: begin
          if (div_access) begin
            st_next.divisor_high_byte = pwdata[7:0];
          end else begin
            st_next.irq_enable = pwdata[7:0] & udi_pkg::IRQ_EN_USED;
          end
        end
        udi_pkg::ADDR_LINE_CONTROL: begin
          st_next.line_control = pwdata[7:0];
          // Changing the FIFO mode flushes both paths.
          if (pwdata[udi_pkg::BIT_FIFO_ENABLE] != fifo_en) begin
            st_next.rx_wp  = 4'h0;
            st_next.rx_rp  = 4'h0;
            st_next.rx_cnt = 5'h00;
            st_next.tx_wp  = 4'h0;
            st_next.tx_rp  = 4'h0;
            st_next.tx_cnt = 5'h00;
          end
        end
        udi_pkg::ADDR_IRQ_STATUS: irq_clr = pwdata[2:0];
        udi_pkg::ADDR_IRQ_MASK:   st_next.irq_mask = pwdata[2:0];
        default:                  st_next.pslverr = 1'b1;
      endcase
    end
    if (tx_write) begin
      if (st_next.tx_cnt < cap(fifo_en)) begin
        st_next.tx_mem[st_next.tx_wp] = pwdata[7:0];
        st_next.tx_wp  = st_next.tx_wp + (fifo_en ? 4'h1 : 4'h0);
        st_next.tx_cnt = st_next.tx_cnt + 5'h01;
      end else if (!fifo_en) begin
        st_next.tx_mem[st_next.tx_wp] = pwdata[7:0];
      end
    end
    // Receive store; a pop in the same cycle makes room first.
    if (rx_push) begin
      irq_set[udi_pkg::IRQ_RX] =
        st_reg.irq_enable[udi_pkg::BIT_RX_AVAIL_EN];
      if (st_next.rx_cnt < cap(fifo_en)) begin
        st_next.rx_mem[st_next.rx_wp] = st_reg.rx_shift;
        st_next.rx_wp  = st_next.rx_wp + (fifo_en ? 4'h1 : 4'h0);
        st_next.rx_cnt = st_next.rx_cnt + 5'h01;
      end else begin
        if (!fifo_en) begin
          st_next.rx_mem[st_next.rx_wp] = st_reg.rx_shift;
        end
        st_next.overrun = 1'b1;
        irq_set[udi_pkg::IRQ_OVR] =
          st_reg.irq_enable[udi_pkg::BIT_LINE_STATUS_EN];
      end
    end
    // New events beat a simultaneous write-one-to-clear.
    st_next.irq_status = (st_reg.irq_status & ~irq_clr) | irq_set;
    st_next.irq        = |(st_next.irq_status & st_next.irq_mask);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg                   <= '0;
      st_reg.rx_state          <= udi_pkg::S_IDLE;
      st_reg.tx_state          <= udi_pkg::S_IDLE;
      st_reg.divisor_low_byte  <= udi_pkg::RESET_BYTE;
      st_reg.divisor_high_byte <= udi_pkg::RESET_BYTE;
      st_reg.irq_enable        <= udi_pkg::RESET_BYTE;
      st_reg.irq_mask          <= udi_pkg::RESET_IRQ;
      st_reg.tx_line           <= 1'b1;
      st_reg.sout              <= 1'b1;
      st_reg.sir_out_n         <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata    = st_reg.prdata;
  assign pready    = st_reg.pready;
  assign pslverr   = st_reg.pslverr;
  assign sout      = st_reg.sout;
  assign sir_out_n = st_reg.sir_out_n;
  assign irq       = st_reg.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_RX_READY: assert property (
    (rd && paddr == udi_pkg::ADDR_LINE_STATUS && st_reg.rx_cnt == 5'h00)
    |=> !prdata[udi_pkg::BIT_RX_READY])
    else $error("Receive-ready reported with an empty receive path.");
  AST_RX_REPLACE: assert property (
    (rx_push && !fifo_en && st_reg.rx_cnt == 5'h01 && !rd && !wr)
    |=> st_reg.overrun && st_reg.rx_cnt == 5'h01
        && st_reg.rx_mem[st_reg.rx_wp] == $past(st_reg.rx_shift))
    else $error("Unread byte was not replaced with overrun flagged.");
  AST_RX_FULL_KEEP: assert property (
    (rx_push && fifo_en && st_reg.rx_cnt == udi_pkg::FIFO_CAP && !rd && !wr)
    |=> st_reg.overrun && $stable(st_reg.rx_mem) && $stable(st_reg.rx_wp))
    else $error("Full receive FIFO changed on an overrun.");
  AST_TX_FULL_DROP: assert property (
    (tx_write && fifo_en && st_reg.tx_cnt == udi_pkg::FIFO_CAP)
    |=> $stable(st_reg.tx_mem) && st_reg.tx_wp == $past(st_reg.tx_wp))
    else $error("Write into a full transmit FIFO was stored.");
  AST_TX_SINGLE: assert property (
    (tx_write && !fifo_en && st_reg.tx_cnt == 5'h00 && !st_reg.tick)
    |=> st_reg.tx_cnt == 5'h01)
    else $error("Single holding write did not fill the holding stage.");
  AST_DIV_LOW: assert property (
    (wr && paddr == udi_pkg::ADDR_SHARED_DATA && div_access)
    |=> st_reg.divisor_low_byte == $past(pwdata[7:0])
        && st_reg.tx_cnt <= $past(st_reg.tx_cnt))
    else $error("Divisor access write did not land in the divisor.");
  AST_BAUD_SPACING: assert property (
    (st_reg.tick && divisor == 16'h0002 && $stable(divisor))
    |=> !st_reg.tick ##1 st_reg.tick)
    else $error("Rate tick spacing does not follow the divisor.");
  AST_DIV_HIGH_READ: assert property (
    (rd && paddr == udi_pkg::ADDR_IRQ_EN_DIVHI && div_access)
    |=> prdata[7:0] == $past(st_reg.divisor_high_byte))
    else $error("Divisor high byte not returned during divisor access.");
  AST_IR_IDLE: assert property (
    (ir_mode && $past(ir_mode)) |-> sout)
    else $error("Serial output moved while infrared mode was active.");

endmodule // udi_uart

// [test/udi_remote.sv]
`timescale 1ns/1ps
module udi_remote #(
  parameter int BIT_CYC = 32
) (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] got_q[$];
  logic [7:0] rx_b;

  initial line_out = 1'b1;

  // Each bit is sampled at its middle, so a wrong bit rate lands on a
  // neighbouring bit and shows up as a wrong byte.
  initial begin
    forever begin
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        rx_b[i] = line_in;
      end
      repeat (BIT_CYC) @(posedge clk);
      if (line_in === 1'b1)
        got_q.push_back(rx_b);
    end
  end

  // Start bit, eight data bits with the least significant first, stop bit.
  task automatic send(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      line_out <= frame[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask
endmodule // udi_remote

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
  localparam int DIV = 2;
  localparam int BIT_CYC = 16 * DIV;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic        sout, sir_out_n, irq, ir_on, link, err;
  logic [31:0] paddr, pwdata, prdata, rd, seed;
  logic [7:0]  b;
  int          n_errors, checked;
  int          tx_exp[$];
  int          rx_exp[$];

  udi_uart dut (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sin(ir_on | link),
    .sir_in(~ir_on | link), .sout(sout), .sir_out_n(sir_out_n),
    .irq(irq));
  udi_remote #(.BIT_CYC(BIT_CYC)) peer (
    .clk(clk), .line_in(ir_on ? sir_out_n : sout), .line_out(link));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr_en, input logic [31:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      n_errors++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask

  task automatic rdr(input logic [31:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask

  task automatic wait_rx();
    int n;
    n = 0;
    do begin
      rdr(udi_pkg::ADDR_LINE_STATUS);
      n++;
    end while (rd[udi_pkg::BIT_RX_READY] !== 1'b1 && n < 400);
    if (rd[udi_pkg::BIT_RX_READY] !== 1'b1)
      n_errors++;
  endtask

  task automatic check_tx();
    check(32'(peer.got_q.size()), 32'(tx_exp.size()));
    while (peer.got_q.size() > 0 && tx_exp.size() > 0)
      check(32'(peer.got_q.pop_front()), 32'(tx_exp.pop_front()));
    peer.got_q.delete();
    tx_exp.delete();
  endtask

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // The span covers the longest run of frames with a wide margin.
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    stop_test();
  end

  initial begin
    {nrst, psel, penable, pwrite, ir_on} = 5'h00;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    seed = 32'h000160AA;
    n_errors = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rdr(udi_pkg::ADDR_SHARED_DATA);
    check(rd, 32'h00000000);
    rdr(udi_pkg::ADDR_IRQ_EN_DIVHI);
    check(rd, 32'h00000000);
    rdr(udi_pkg::ADDR_LINE_STATUS);
    check(rd & 32'h00000023, 32'h00000020);
    rdr(32'h50001120);
    check(32'(err), 32'h00000001);
    end_test("reset");
    wr(udi_pkg::ADDR_LINE_CONTROL, 8'h80);
    wr(udi_pkg::ADDR_SHARED_DATA, 8'h5A);
    wr(udi_pkg::ADDR_IRQ_EN_DIVHI, 8'hC3);
    rdr(udi_pkg::ADDR_SHARED_DATA);
    check(rd, 32'h0000005A);
    rdr(udi_pkg::ADDR_IRQ_EN_DIVHI);
    check(rd, 32'h000000C3);
    wr(udi_pkg::ADDR_LINE_CONTROL, 8'h00);
    wr(udi_pkg::ADDR_IRQ_EN_DIVHI, 8'hFF);
    rdr(udi_pkg::ADDR_IRQ_EN_DIVHI);
    check(rd, 32'h0000008F);
    wr(udi_pkg::ADDR_LINE_CONTROL, 8'h80);
    rdr(udi_pkg::ADDR_IRQ_EN_DIVHI);
    check(rd, 32'h000000C3);
    wr(udi_pkg::ADDR_SHARED_DATA, 8'(DIV));
    wr(udi_pkg::ADDR_IRQ_EN_DIVHI, 8'h00);
    wr(udi_pkg::ADDR_LINE_CONTROL, 8'h00);
    wr(udi_pkg::ADDR_IRQ_EN_DIVHI, 8'h05);
    wr(udi_pkg::ADDR_IRQ_MASK, 8'h01);
    end_test("divisor");
    // The second write lands while the first byte shifts out, the third
    // overwrites it before the holding register empties again.
    for (int i = 0; i < 3; i++) begin
      b = rnd();
      wr(udi_pkg::ADDR_SHARED_DATA, b);
      if (i != 1)
        tx_exp.push_back(int'(b));
      if (i == 1) begin
        rdr(udi_pkg::ADDR_LINE_STATUS);
        check(32'(rd[5]), 32'h00000000);
      end
    end
    repeat (25 * BIT_CYC) @(posedge clk);
    check_tx();
    end_test("transmit");
    b = rnd();
    peer.send(b);
    wait_rx();
    check(32'(irq), 32'h00000001);
    rdr(udi_pkg::ADDR_SHARED_DATA);
    check(rd, 32'(b));
    wr(udi_pkg::ADDR_IRQ_STATUS, 8'h07);
    wr(udi_pkg::ADDR_IRQ_MASK, 8'h00);
    check(32'(irq), 32'h00000000);
    peer.send(rnd());
    b = rnd();
    peer.send(b);
    repeat (BIT_CYC) @(posedge clk);
    rdr(udi_pkg::ADDR_LINE_STATUS);
    check(32'(rd[1:0]), 32'h00000003);
    rdr(udi_pkg::ADDR_IRQ_STATUS);
    check(32'(rd[1:0]), 32'h00000003);
    check(32'(irq), 32'h00000000);
    rdr(udi_pkg::ADDR_SHARED_DATA);
    check(rd, 32'(b));
    wr(udi_pkg::ADDR_IRQ_MASK, 8'h02);
    rdr(udi_pkg::ADDR_IRQ_MASK);
    check(32'(irq), 32'h00000001);
    wr(udi_pkg::ADDR_IRQ_STATUS, 8'h03);
    rdr(udi_pkg::ADDR_IRQ_MASK);
    check(32'(irq), 32'h00000000);
    end_test("receive");
    wr(udi_pkg::ADDR_LINE_CONTROL, 8'h02);
    ir_on <= 1'b1;
    b = rnd();
    peer.send(b);
    wait_rx();
    rdr(udi_pkg::ADDR_SHARED_DATA);
    check(rd, 32'(b));
    b = rnd();
    tx_exp.push_back(int'(b));
    wr(udi_pkg::ADDR_SHARED_DATA, b);
    repeat (12 * BIT_CYC) @(posedge clk);
    check_tx();
    wr(udi_pkg::ADDR_LINE_CONTROL, 8'h01);
    ir_on <= 1'b0;
    end_test("infrared");
    wr(udi_pkg::ADDR_IRQ_EN_DIVHI, 8'h87);
    // One byte goes to the shifter, the FIFO takes the next ones until
    // full, and the last write must vanish.
    for (int i = 0; i < udi_pkg::FIFO_DEPTH + 2; i++) begin
      b = rnd();
      wr(udi_pkg::ADDR_SHARED_DATA, b);
      if (i <= udi_pkg::FIFO_DEPTH)
        tx_exp.push_back(int'(b));
      if (i == 1) begin
        rdr(udi_pkg::ADDR_LINE_STATUS);
        check(32'(rd[5]), 32'h00000001);
      end
    end
    repeat (180 * BIT_CYC) @(posedge clk);
    check_tx();
    rdr(udi_pkg::ADDR_IRQ_STATUS);
    check(32'(rd[2]), 32'h00000001);
    for (int i = 0; i <= udi_pkg::FIFO_DEPTH; i++) begin
      b = rnd();
      rx_exp.push_back(int'(b));
      peer.send(b);
    end
    repeat (BIT_CYC) @(posedge clk);
    rdr(udi_pkg::ADDR_LINE_STATUS);
    check(32'(rd[1:0]), 32'h00000003);
    for (int i = 0; i < udi_pkg::FIFO_DEPTH; i++) begin
      rdr(udi_pkg::ADDR_SHARED_DATA);
      check(rd, 32'(rx_exp.pop_front()));
    end
    rdr(udi_pkg::ADDR_LINE_STATUS);
    check(32'(rd[0]), 32'h00000000);
    end_test("fifo");
    stop_test();
  end
endmodule // testbench
